/* File: hw/spdf_packet_drain.sv */
// Purpose: Drains the packet queue in four-packet groups toward a MAC
// Assumes: Control inputs come from logic on pclk; APB slave
// Notes: APB answers in the first access cycle, no wait states
`timescale 1ns/1ps
`default_nettype none

module spdf_packet_drain
  import spdf_pkg::*;
#(
  parameter int unsigned packet_length_bytes = 1024,
  parameter int unsigned byte_counter_width = 16,
  parameter int unsigned gap_counter_width = 5,
  parameter int unsigned group_counter_width = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stream_request,
  input wire logic go,
  input wire logic queue_fill_ready,
  input wire logic flag_clear,
  output logic queue_pop,
  output logic queue_clear,
  output logic frame_begin_strobe_n,
  output logic frame_final_strobe_n,
  output logic payload_valid_n,
  output logic group_complete,
  output logic illegal_state_flag,
  output logic irq,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Parameter
  if (packet_length_bytes < 3 ||
      packet_length_bytes > (1 << byte_counter_width)) begin : g_bad_len
    $error("packet_length_bytes must be at least 3 and fit the counter");
  end
  if (SPDF_GAP_CYCLES > (1 << gap_counter_width)) begin : g_bad_gap
    $error("gap_counter_width too small for the packet gap");
  end
  if (SPDF_GROUP_PACKETS >= (1 << group_counter_width)) begin : g_bad_grp
    $error("group_counter_width too small for the group size");
  end

  localparam logic [byte_counter_width-1:0] BODY_LAST =
    byte_counter_width'(packet_length_bytes - 2);
  localparam logic [gap_counter_width-1:0] GAP_LAST =
    gap_counter_width'(SPDF_GAP_CYCLES - 1);
  localparam logic [group_counter_width-1:0] GROUP_SIZE =
    group_counter_width'(SPDF_GROUP_PACKETS);

  // Sequencer state
  spdf_state_t state, next_state;
  logic [byte_counter_width-1:0] byte_cnt, next_byte_cnt;
  logic [gap_counter_width-1:0] gap_cnt, next_gap_cnt;
  logic [group_counter_width-1:0] packet_cnt, next_packet_cnt;
  logic request_q, next_request_q;
  logic illegal_seen;
  spdf_strobes_t strobes, next_strobes;
  logic next_illegal_state_flag;

  // Register state
  logic ctrl_run, next_ctrl_run;
  logic [SPDF_INT_WIDTH-1:0] int_status, next_int_status;
  logic [SPDF_INT_WIDTH-1:0] int_mask, next_int_mask;
  logic next_irq;
  spdf_apb_rsp_t apb_rsp, next_apb_rsp;

  logic req_eff;
  logic wr_access;
  logic rd_access;
  logic sw_flag_clear;
  logic [SPDF_INT_WIDTH-1:0] int_events;

  // Software can hold the sequencer off by clearing the run bit
  assign req_eff = stream_request & ctrl_run;
  assign wr_access = psel & penable & apb_rsp.pready & pwrite;
  assign rd_access = psel & penable & apb_rsp.pready & ~pwrite;
  assign sw_flag_clear = wr_access && paddr == SPDF_ADDR_CTRL &&
    pwdata[SPDF_CTRL_FLAG_CLEAR_BIT];

  // Next state and counters, all on pclk
  always_comb begin
    next_state = state;
    next_byte_cnt = byte_cnt;
    next_gap_cnt = gap_cnt;
    next_packet_cnt = packet_cnt;
    next_request_q = req_eff;
    illegal_seen = 1'b0;
    unique case (state)
      SPDF_IDLE: begin
        if (req_eff && !request_q) begin
          next_state = SPDF_CLEAR_A;
        end
      end
      SPDF_CLEAR_A: begin
        next_state = SPDF_CLEAR_B;
      end
      SPDF_CLEAR_B: begin
        next_state = SPDF_AWAIT_GO;
      end
      SPDF_AWAIT_GO: begin
        if (go) begin
          next_state = SPDF_AWAIT_FILL;
        end
      end
      SPDF_AWAIT_FILL: begin
        // Fill ready is trusted as the queue threshold signal
        if (queue_fill_ready) begin
          next_state = SPDF_START;
          next_byte_cnt = '0;
        end
      end
      SPDF_START: begin
        next_state = SPDF_BODY;
        next_byte_cnt = byte_counter_width'(1);
      end
      SPDF_BODY: begin
        if (byte_cnt == BODY_LAST) begin
          next_state = SPDF_STOP;
        end else begin
          next_byte_cnt = byte_cnt + 1'b1;
        end
      end
      SPDF_STOP: begin
        next_state = SPDF_GAP;
        next_gap_cnt = '0;
        next_packet_cnt = packet_cnt + 1'b1;
      end
      SPDF_GAP: begin
        if (gap_cnt == GAP_LAST) begin
          next_state = SPDF_DONE;
        end else begin
          next_gap_cnt = gap_cnt + 1'b1;
        end
      end
      SPDF_DONE: begin
        if (packet_cnt < GROUP_SIZE) begin
          next_state = SPDF_START;
          next_byte_cnt = '0;
        end else begin
          next_state = SPDF_FINISH;
        end
      end
      SPDF_FINISH: begin
        next_packet_cnt = '0;
        if (req_eff) begin
          next_state = SPDF_AWAIT_GO;
        end else begin
          next_state = SPDF_IDLE;
        end
      end
      default: begin
        // Recover to idle rather than lock up
        illegal_seen = 1'b1;
        next_state = SPDF_IDLE;
        next_byte_cnt = '0;
        next_gap_cnt = '0;
        next_packet_cnt = '0;
      end
    endcase
  end

  // Strobes follow the state being entered so they line up with it
  always_comb begin
    next_strobes = SPDF_STROBES_RESET;
    unique case (next_state)
      SPDF_CLEAR_A, SPDF_CLEAR_B: begin
        next_strobes.queue_clear = 1'b1;
      end
      SPDF_START: begin
        next_strobes.queue_pop = 1'b1;
        next_strobes.frame_begin_strobe_n = 1'b0;
        next_strobes.payload_valid_n = 1'b0;
      end
      SPDF_BODY: begin
        next_strobes.queue_pop = 1'b1;
        next_strobes.payload_valid_n = 1'b0;
      end
      SPDF_STOP: begin
        next_strobes.queue_pop = 1'b1;
        next_strobes.frame_final_strobe_n = 1'b0;
        next_strobes.payload_valid_n = 1'b0;
      end
      SPDF_FINISH: begin
        next_strobes.group_complete = 1'b1;
      end
      default: begin
        next_strobes = SPDF_STROBES_RESET;
      end
    endcase
    // Set wins over clear
    next_illegal_state_flag = illegal_seen |
      (illegal_state_flag & ~(flag_clear | sw_flag_clear));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SPDF_IDLE;
      byte_cnt <= '0;
      gap_cnt <= '0;
      packet_cnt <= '0;
      request_q <= 1'b0;
      strobes <= SPDF_STROBES_RESET;
      illegal_state_flag <= 1'b0;
    end else begin
      state <= next_state;
      byte_cnt <= next_byte_cnt;
      gap_cnt <= next_gap_cnt;
      packet_cnt <= next_packet_cnt;
      request_q <= next_request_q;
      strobes <= next_strobes;
      illegal_state_flag <= next_illegal_state_flag;
    end
  end

  assign queue_pop = strobes.queue_pop;
  assign queue_clear = strobes.queue_clear;
  assign frame_begin_strobe_n = strobes.frame_begin_strobe_n;
  assign frame_final_strobe_n = strobes.frame_final_strobe_n;
  assign payload_valid_n = strobes.payload_valid_n;
  assign group_complete = strobes.group_complete;

  // Interrupt events, one cycle each
  always_comb begin
    int_events = '0;
    int_events[SPDF_INT_GROUP_BIT] = next_strobes.group_complete &
      ~strobes.group_complete;
    int_events[SPDF_INT_ILLEGAL_BIT] = illegal_seen;
    int_events[SPDF_INT_PACKET_BIT] = (state == SPDF_STOP);
  end

  // APB slave and interrupt registers
  always_comb begin
    next_ctrl_run = ctrl_run;
    next_int_mask = int_mask;
    next_int_status = int_status;
    next_apb_rsp = '0;
    if (wr_access && paddr == SPDF_ADDR_CTRL) begin
      next_ctrl_run = pwdata[SPDF_CTRL_RUN_BIT];
    end
    if (wr_access && paddr == SPDF_ADDR_INT_MASK) begin
      next_int_mask = pwdata[SPDF_INT_WIDTH-1:0];
    end
    // Clear only what the read returned, so a bit set late is not lost
    if (rd_access && paddr == SPDF_ADDR_INT_STATUS) begin
      next_int_status = int_status &
        ~apb_rsp.prdata[SPDF_INT_WIDTH-1:0];
    end
    next_int_status = next_int_status | int_events;
    next_irq = |(next_int_status & next_int_mask);
    if (psel && !penable) begin
      next_apb_rsp.pready = 1'b1;
      unique case (paddr)
        SPDF_ADDR_CTRL: begin
          next_apb_rsp.prdata = {31'h0000_0000, ctrl_run};
        end
        SPDF_ADDR_STATUS: begin
          next_apb_rsp.prdata = {4'h0, group_counter_width'(packet_cnt),
            (16 - group_counter_width)'(0), illegal_state_flag,
            state};
        end
        SPDF_ADDR_INT_STATUS: begin
          next_apb_rsp.prdata = {29'h0000_0000, int_status};
        end
        SPDF_ADDR_INT_MASK: begin
          next_apb_rsp.prdata = {29'h0000_0000, int_mask};
        end
        default: begin
          next_apb_rsp.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_run <= SPDF_CTRL_RUN_RESET;
      int_mask <= SPDF_INT_MASK_RESET;
      int_status <= '0;
      irq <= 1'b0;
      apb_rsp <= '0;
    end else begin
      ctrl_run <= next_ctrl_run;
      int_mask <= next_int_mask;
      int_status <= next_int_status;
      irq <= next_irq;
      apb_rsp <= next_apb_rsp;
    end
  end

  assign prdata = apb_rsp.prdata;
  assign pready = apb_rsp.pready;
  assign pslverr = apb_rsp.pslverr;

endmodule // spdf_packet_drain

`default_nettype wire

/* File: hw/spdf_pkg.sv */
// Purpose: Constants, states and carrier types for the packet drain block
// Assumes: One 125 MHz clock, APB register access, 32-bit data
// Notes: Imported by spdf_packet_drain.sv and by the bench
`default_nettype none

package spdf_pkg;

  localparam int unsigned SPDF_CLK_MHZ = 125;
  localparam int unsigned SPDF_GROUP_PACKETS = 4;
  localparam int unsigned SPDF_GAP_CYCLES = 25;
  localparam int unsigned SPDF_FILL_THRESHOLD = 32'h0000_0BB8;

  // Register byte addresses
  localparam logic [7:0] SPDF_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SPDF_ADDR_STATUS = 8'h04;
  localparam logic [7:0] SPDF_ADDR_INT_STATUS = 8'h08;
  localparam logic [7:0] SPDF_ADDR_INT_MASK = 8'h0C;

  // Control fields
  localparam int unsigned SPDF_CTRL_RUN_BIT = 0;
  localparam int unsigned SPDF_CTRL_FLAG_CLEAR_BIT = 1;
  localparam logic SPDF_CTRL_RUN_RESET = 1'b1;

  // Interrupt event bit positions
  localparam int unsigned SPDF_INT_GROUP_BIT = 0;
  localparam int unsigned SPDF_INT_ILLEGAL_BIT = 1;
  localparam int unsigned SPDF_INT_PACKET_BIT = 2;
  localparam int unsigned SPDF_INT_WIDTH = 3;
  localparam logic [2:0] SPDF_INT_MASK_RESET = 3'h0;

  typedef enum logic [10:0] {
    SPDF_IDLE       = 11'h001,
    SPDF_CLEAR_A    = 11'h002,
    SPDF_CLEAR_B    = 11'h004,
    SPDF_AWAIT_GO   = 11'h008,
    SPDF_AWAIT_FILL = 11'h010,
    SPDF_START      = 11'h020,
    SPDF_BODY       = 11'h040,
    SPDF_STOP       = 11'h080,
    SPDF_GAP        = 11'h100,
    SPDF_DONE       = 11'h200,
    SPDF_FINISH     = 11'h400
  } spdf_state_t;

  // Strobes toward the MAC and queue, all registered
  typedef struct packed {
    logic queue_pop;
    logic queue_clear;
    logic frame_begin_strobe_n;
    logic frame_final_strobe_n;
    logic payload_valid_n;
    logic group_complete;
  } spdf_strobes_t;

  localparam spdf_strobes_t SPDF_STROBES_RESET = '{
    queue_pop: 1'b0, queue_clear: 1'b0, frame_begin_strobe_n: 1'b1,
    frame_final_strobe_n: 1'b1, payload_valid_n: 1'b1, group_complete: 1'b0};

  // APB answer, registered in the setup cycle
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } spdf_apb_rsp_t;

endpackage

`default_nettype wire

/* File: test/spdf_packet_drain_sva.sv */
// Purpose: Port assertions for the packet drain block
// Assumes: One clock, async active-low reset
// Notes: Helper counters track pops and packets within a group
`timescale 1ns/1ps
`default_nettype none
module spdf_packet_drain_sva #(
  parameter int unsigned packet_length_bytes = 1024
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flag_clear,
  input wire logic queue_pop,
  input wire logic queue_clear,
  input wire logic frame_begin_strobe_n,
  input wire logic frame_final_strobe_n,
  input wire logic payload_valid_n,
  input wire logic group_complete,
  input wire logic illegal_state_flag,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready
);
  int unsigned run;
  logic [1:0] pk;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run <= 0;
      pk <= 2'h0;
    end else begin
      run <= queue_pop ? run + 1 : 0;
      pk <= pk + {1'b0, !frame_final_strobe_n};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_clear;
    $rose(queue_clear) |=> queue_clear ##1 !queue_clear;
  endproperty
  a_clear: assert property (p_clear) else $error("clear length");
  property p_begin;
    !frame_begin_strobe_n |-> queue_pop && run == 0;
  endproperty
  a_begin: assert property (p_begin) else $error("begin strobe");
  property p_body;
    queue_pop && run != 0 |-> frame_begin_strobe_n;
  endproperty
  a_body: assert property (p_body) else $error("body strobe");
  property p_final;
    !frame_final_strobe_n |-> queue_pop && run == packet_length_bytes - 1
      ##1 !queue_pop;
  endproperty
  a_final: assert property (p_final) else $error("final strobe");
  property p_valid;
    queue_pop != payload_valid_n;
  endproperty
  a_valid: assert property (p_valid) else $error("valid level");
  property p_next;
    !frame_final_strobe_n && pk != 2'h3 |-> ##27 !frame_begin_strobe_n;
  endproperty
  a_next: assert property (p_next) else $error("packet gap");
  property p_group;
    !frame_final_strobe_n && pk == 2'h3 |-> ##27 group_complete
      ##1 !group_complete;
  endproperty
  a_group: assert property (p_group) else $error("group pulse");
  property p_flag;
    illegal_state_flag && !flag_clear |=> illegal_state_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not sticky");
  property p_apb;
    psel && !penable |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer");
endmodule // spdf_packet_drain_sva
bind spdf_packet_drain spdf_packet_drain_sva #(
  .packet_length_bytes(packet_length_bytes)
) u_sva (
  .pclk(pclk), .presetn(presetn), .flag_clear(flag_clear),
  .queue_pop(queue_pop), .queue_clear(queue_clear),
  .frame_begin_strobe_n(frame_begin_strobe_n),
  .frame_final_strobe_n(frame_final_strobe_n),
  .payload_valid_n(payload_valid_n), .group_complete(group_complete),
  .illegal_state_flag(illegal_state_flag), .psel(psel),
  .penable(penable), .pready(pready)
);
`default_nettype wire

/* File: test/spdf_queue_model.sv */
// Purpose: Packet queue model that raises fill ready
// Assumes: Writer adds fill_step entries each cycle
// Notes: Small fill_step makes the queue slow to become ready
`timescale 1ns/1ps
`default_nettype none
module spdf_queue_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] fill_step,
  input wire logic queue_pop,
  input wire logic queue_clear,
  output logic queue_fill_ready
);
  int level;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 0;
      queue_fill_ready <= 1'b0;
    end else begin
      level <= queue_clear ? 0 : level + int'(fill_step) - int'(queue_pop);
      queue_fill_ready <= level >= 32'h0000_0BB8;
    end
  end
endmodule // spdf_queue_model
`default_nettype wire

/* File: test/spdf_packet_drain_tb.sv */
// Purpose: Self-checking bench for the packet drain block
// Assumes: Packets of 4 bytes keep the run short
// Notes: Monitor totals are compared with counts kept by the bench
`timescale 1ns/1ps
`default_nettype none
module spdf_packet_drain_tb;
  import spdf_pkg::*;
  localparam int L = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic stream_request = 1'b0;
  logic go = 1'b0;
  logic flag_clear = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] fill_step = 8'h04;
  logic queue_fill_ready, queue_pop, queue_clear, group_complete, irq;
  logic frame_begin_strobe_n, frame_final_strobe_n, payload_valid_n;
  logic illegal_state_flag, pready, pslverr, er;
  logic [31:0] prdata, rd;
  int bad_count = 0;
  int compares = 0;
  int pops = 0, begins = 0, finals = 0, clears = 0, grps = 0;
  // Byte position inside the packet, kept by the bench from the rules
  int idx = 0;
  always #4 pclk = ~pclk;
  spdf_packet_drain #(.packet_length_bytes(L)) DUT (
    .pclk(pclk), .presetn(presetn), .stream_request(stream_request),
    .go(go), .queue_fill_ready(queue_fill_ready), .flag_clear(flag_clear),
    .queue_pop(queue_pop), .queue_clear(queue_clear),
    .frame_begin_strobe_n(frame_begin_strobe_n),
    .frame_final_strobe_n(frame_final_strobe_n),
    .payload_valid_n(payload_valid_n), .group_complete(group_complete),
    .illegal_state_flag(illegal_state_flag), .irq(irq), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  spdf_queue_model u_queue (.pclk(pclk), .presetn(presetn),
    .fill_step(fill_step), .queue_pop(queue_pop), .queue_clear(queue_clear),
    .queue_fill_ready(queue_fill_ready));
  always @(posedge pclk) begin
    if (presetn) begin
      pops += queue_pop;
      begins += !frame_begin_strobe_n;
      finals += !frame_final_strobe_n;
      clears += queue_clear;
      grps += group_complete;
      if (queue_pop) begin
        check("begin_n", frame_begin_strobe_n, idx != 0);
        check("final_n", frame_final_strobe_n, idx != L - 1);
        idx = (idx + 1) % L;
      end else begin
        check("idle begin_n", frame_begin_strobe_n, 1);
        check("idle final_n", frame_final_strobe_n, 1);
      end
      check("valid_n", payload_valid_n, !queue_pop);
    end
  end
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Idle cycle first, so a release and a new setup never share an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic wait_grps(input int n);
    int k;
    k = 0;
    while (grps < n && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 3000) begin
      bad_count++;
      print_verdict();
    end
  endtask
  // Totals expected after g complete groups
  task automatic check_totals(input int g);
    check("pops", pops, g * 4 * L);
    check("begins", begins, g * 4);
    check("finals", finals, g * 4);
    check("groups", grps, g);
  endtask
  initial begin
    void'($urandom(32'hd0c3));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("strobes", {queue_pop, queue_clear, frame_begin_strobe_n,
      frame_final_strobe_n, payload_valid_n, group_complete}, 32'h0E);
    check("flag reset", illegal_state_flag, 0);
    apb(1'b0, SPDF_ADDR_CTRL, 32'h0);
    check("ctrl", rd, 32'h1);
    apb(1'b0, SPDF_ADDR_STATUS, 32'h0);
    check("status", rd, 32'h1);
    apb(1'b0, SPDF_ADDR_INT_MASK, 32'h0);
    check("mask", rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check("unmapped", er, 32'h1);
    check("unmapped data", rd, 32'h0);
    $display("done reset");
    stream_request <= 1'b1;
    repeat (20) @(posedge pclk);
    check("clears", clears, 2);
    check("no go", pops, 0);
    repeat ($urandom_range(0, 15)) @(posedge pclk);
    go <= 1'b1;
    repeat (2) @(posedge pclk);
    go <= 1'b0;
    wait_grps(1);
    repeat (5) @(posedge pclk);
    check_totals(1);
    check("irq masked", irq, 0);
    apb(1'b0, SPDF_ADDR_STATUS, 32'h0);
    check("await go", rd[11:0], 32'h8);
    apb(1'b0, SPDF_ADDR_INT_STATUS, 32'h0);
    check("int", rd, 32'h5);
    apb(1'b0, SPDF_ADDR_INT_STATUS, 32'h0);
    check("int clr", rd, 32'h0);
    apb(1'b1, SPDF_ADDR_INT_MASK, 32'h1);
    $display("done group one");
    fill_step <= 8'($urandom_range(16, 64));
    repeat ($urandom_range(1, 15)) @(posedge pclk);
    go <= 1'b1;
    repeat (10) @(posedge pclk);
    stream_request <= 1'b0;
    go <= 1'b0;
    wait_grps(2);
    repeat (3) @(posedge pclk);
    check("irq", irq, 1);
    check_totals(2);
    check("one clear", clears, 2);
    apb(1'b0, SPDF_ADDR_STATUS, 32'h0);
    check("idle", rd[11:0], 32'h1);
    apb(1'b0, SPDF_ADDR_INT_STATUS, 32'h0);
    repeat (3) @(posedge pclk);
    check("irq clr", irq, 0);
    flag_clear <= 1'b1;
    apb(1'b1, SPDF_ADDR_CTRL, 32'h3);
    flag_clear <= 1'b0;
    apb(1'b0, SPDF_ADDR_CTRL, 32'h0);
    check("run kept", rd, 32'h1);
    check("flag", illegal_state_flag, 0);
    stream_request <= 1'b1;
    repeat (10) @(posedge pclk);
    check("reclear", clears, 4);
    $display("done group two");
    print_verdict();
  end
endmodule // spdf_packet_drain_tb
`default_nettype wire
